/* verilog/ldc_defs.vh */
`ifndef LDC_DEFS_VH
`define LDC_DEFS_VH

// ****************************************************************
// Port offsets, lower group (channels 0-3)
// ****************************************************************
`define LDC_LO_CHANNEL_MODE     8'h0B
`define LDC_LO_CLEAR_BYTE_PTR   8'h0C
`define LDC_LO_MASTER_CLEAR     8'h0D
`define LDC_LO_CLEAR_MASK       8'h0E
`define LDC_LO_ALL_MASK         8'h0F
// Word (address/count) ports 00-07: upper five address bits
`define LDC_LO_WORD_TOP         5'h00

// ****************************************************************
// Port offsets, upper group (channels 4-7)
// ****************************************************************
`define LDC_HI_CHANNEL_MODE     8'hD6
`define LDC_HI_CLEAR_BYTE_PTR   8'hD8
`define LDC_HI_MASTER_CLEAR     8'hDA
`define LDC_HI_CLEAR_MASK       8'hDC
`define LDC_HI_ALL_MASK         8'hDE
// Word ports C0-CE, even addresses only: upper nibble
`define LDC_HI_WORD_TOP         4'hC

// ****************************************************************
// Channel mode register fields
// ****************************************************************
`define LDC_MODE_XFER_HI        7
`define LDC_MODE_XFER_LO        6
`define LDC_MODE_DEC_BIT        5
`define LDC_MODE_AUTO_BIT       4
`define LDC_MODE_TYPE_HI        3
`define LDC_MODE_TYPE_LO        2
`define LDC_MODE_SEL_HI         1
`define LDC_MODE_SEL_LO         0
`define LDC_MODE_RESET          6'h00

`define LDC_XFER_DEMAND         2'h0
`define LDC_XFER_SINGLE         2'h1
`define LDC_XFER_RESERVED       2'h2
`define LDC_XFER_CASCADE        2'h3

`define LDC_TYPE_VERIFY         2'h0
`define LDC_TYPE_IO_TO_MEM      2'h1
`define LDC_TYPE_MEM_TO_IO      2'h2
`define LDC_TYPE_ILLEGAL        2'h3

// ****************************************************************
// Mask and read values
// ****************************************************************
`define LDC_MASK_RESET          4'hF
`define LDC_MASK_HI             3
`define LDC_MASK_LO             0
`define LDC_UNMAPPED_RDATA      8'hFF

`endif

/* verilog/ldc_channel_mode.v */
`timescale 1ns/1ns
`default_nettype none

`include "ldc_defs.vh"

module ldc_channel_mode (
    input  wire       ref_clk_i,
    input  wire       reset_n_i,
    input  wire       master_clear_i,
    input  wire       mode_write_i,
    input  wire [5:0] mode_data_i,
    input  wire       terminal_count_i,
    output wire [1:0] transfer_mode_o,
    output wire       addr_decrement_o,
    output wire       autoinit_o,
    output wire [1:0] transfer_type_o,
    output reg        reload_o,
    output wire       tc_mask_set_o
);

    // Bits 7:2 of the mode byte, held as 5:0
    reg [5:0] mode;

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode     <= `LDC_MODE_RESET;
            reload_o <= 1'b0;
        end else begin
            if (master_clear_i) begin
                mode <= `LDC_MODE_RESET;
            end else if (mode_write_i) begin
                mode <= mode_data_i;
            end
            reload_o <= terminal_count_i & mode[`LDC_MODE_AUTO_BIT - 2];
        end
    end

    assign transfer_mode_o  = mode[`LDC_MODE_XFER_HI - 2:`LDC_MODE_XFER_LO - 2];
    assign addr_decrement_o = mode[`LDC_MODE_DEC_BIT - 2];
    assign autoinit_o       = mode[`LDC_MODE_AUTO_BIT - 2];
    // Cascade channels never strobe, so the type reads as verify
    assign transfer_type_o  = (transfer_mode_o == `LDC_XFER_CASCADE) ? `LDC_TYPE_VERIFY :
                              mode[`LDC_MODE_TYPE_HI - 2:`LDC_MODE_TYPE_LO - 2];
    assign tc_mask_set_o    = terminal_count_i & ~mode[`LDC_MODE_AUTO_BIT - 2];

endmodule

`default_nettype wire

/* verilog/ldc_buf2.v */
`timescale 1ns/1ns
`default_nettype none

module ldc_buf2 #(
    parameter WIDTH = 8
) (
    input  wire             ref_clk_i,
    input  wire             reset_n_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg [WIDTH-1:0] slot [0:1];
    reg             wr_ptr;
    reg             rd_ptr;
    reg [1:0]       count;

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = slot[rd_ptr];

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            slot[0] <= {WIDTH{1'b0}};
            slot[1] <= {WIDTH{1'b0}};
            wr_ptr  <= 1'b0;
            rd_ptr  <= 1'b0;
            count   <= 2'h0;
        end else begin
            if (push) begin
                slot[wr_ptr] <= in_data_i;
                wr_ptr       <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end

endmodule

`default_nettype wire

/* verilog/ldc_top.v */
// Summary of operation
// - Mode bits 7:6 select demand, single, cascade
// - Mode bit 5 picks increment or decrement
// - Mode bit 4 low ends at terminal count
// - Autoinitialize pulses reload the cycle after terminal count
// - Mode bits 3:2 encode the transfer type
// - Cascade channels ignore their transfer type
// - Mode bits 1:0 choose the written channel
// - Clear byte pointer write clears the pointer
// - Pointer steers low then high byte access
// - Reset and master clear clear the pointer
// - Master clear acts like a hardware reset for its own group
// - Clear mask write enables all four requests
// - All-mask write sets four masks at once
// - Terminal count sets mask unless autoinitializing
// - Reset sets all masks; master clear sets its own group's four masks
// - All-mask read returns the four mask bits
// - Disabling upper group also disables lower group
`timescale 1ns/1ns
`default_nettype none

`include "ldc_defs.vh"

module ldc_top (
    input  wire        ref_clk_i,
    input  wire        reset_n_i,
    // I/O port access
    input  wire [7:0]  io_addr_i,
    input  wire        io_wr_i,
    input  wire        io_rd_i,
    input  wire [7:0]  io_wdata_i,
    output wire        io_ready_o,
    output wire        rd_valid_o,
    input  wire        rd_ready_i,
    output wire [7:0]  rd_data_o,
    // Peripheral and engine side
    input  wire [7:0]  channel_request_line_i,
    input  wire [1:0]  group_disable_i,
    input  wire [7:0]  terminal_count_i,
    output reg  [7:0]  channel_request_gated_o,
    output wire [7:0]  mask_o,
    output wire [15:0] transfer_mode_o,
    output wire [7:0]  addr_decrement_o,
    output wire [7:0]  autoinit_o,
    output wire [15:0] transfer_type_o,
    output wire [7:0]  reload_o,
    output reg  [1:0]  master_clear_o,
    output reg  [1:0]  word_access_o,
    output reg  [1:0]  high_byte_o
);

    // ****************************************************************
    // Access qualification
    // ****************************************************************

    // Reads wait for room in the read buffer; writes are taken unless a read is asserted with them
    wire       rd_take;
    wire       wr_take;
    wire       buf_in_ready;

    assign io_ready_o = buf_in_ready;
    assign rd_take    = io_rd_i & buf_in_ready;
    assign wr_take    = io_wr_i & ~io_rd_i;

    // ****************************************************************
    // Port decode per group
    // ****************************************************************

    wire [1:0] hit_mode;
    wire [1:0] hit_clear_ptr;
    wire [1:0] hit_master_clear;
    wire [1:0] hit_clear_mask;
    wire [1:0] hit_all_mask;
    wire [1:0] hit_word;

    assign hit_mode[0]         = (io_addr_i == `LDC_LO_CHANNEL_MODE);
    assign hit_clear_ptr[0]    = (io_addr_i == `LDC_LO_CLEAR_BYTE_PTR);
    assign hit_master_clear[0] = (io_addr_i == `LDC_LO_MASTER_CLEAR);
    assign hit_clear_mask[0]   = (io_addr_i == `LDC_LO_CLEAR_MASK);
    assign hit_all_mask[0]     = (io_addr_i == `LDC_LO_ALL_MASK);
    assign hit_word[0]         = (io_addr_i[7:3] == `LDC_LO_WORD_TOP);

    // Upper group: same layout at its own ports
    assign hit_mode[1]         = (io_addr_i == `LDC_HI_CHANNEL_MODE);
    assign hit_clear_ptr[1]    = (io_addr_i == `LDC_HI_CLEAR_BYTE_PTR);
    assign hit_master_clear[1] = (io_addr_i == `LDC_HI_MASTER_CLEAR);
    assign hit_clear_mask[1]   = (io_addr_i == `LDC_HI_CLEAR_MASK);
    assign hit_all_mask[1]     = (io_addr_i == `LDC_HI_ALL_MASK);
    assign hit_word[1]         = (io_addr_i[7:4] == `LDC_HI_WORD_TOP) & ~io_addr_i[0];

    // ****************************************************************
    // Commands
    // ****************************************************************

    wire [1:0] do_master_clear;
    wire [1:0] do_clear_ptr;
    wire [1:0] do_clear_mask;
    wire [1:0] do_write_mask;
    wire [1:0] do_mode_write;
    wire [1:0] do_word_access;

    // Data value is ignored for the command ports
    assign do_master_clear = {2{wr_take}} & hit_master_clear;
    assign do_clear_ptr    = {2{wr_take}} & hit_clear_ptr;
    assign do_clear_mask   = {2{wr_take}} & hit_clear_mask;
    assign do_write_mask   = {2{wr_take}} & hit_all_mask;
    assign do_mode_write   = {2{wr_take}} & hit_mode;
    assign do_word_access  = {2{wr_take | rd_take}} & hit_word;

    // ****************************************************************
    // Per-channel mode registers
    // ****************************************************************

    wire [7:0] tc_mask_set;

    genvar c;
    generate
        for (c = 0; c < 8; c = c + 1) begin : g_chan
            wire sel_match;

            // Channel select codes 0-3 map to 4-7 in the upper group
            assign sel_match = (io_wdata_i[`LDC_MODE_SEL_HI:`LDC_MODE_SEL_LO] == c % 4);

            ldc_channel_mode u_mode (
                .ref_clk_i        (ref_clk_i),
                .reset_n_i        (reset_n_i),
                .master_clear_i   (do_master_clear[c / 4]),
                .mode_write_i     (do_mode_write[c / 4] & sel_match),
                .mode_data_i      (io_wdata_i[`LDC_MODE_XFER_HI:`LDC_MODE_TYPE_LO]),
                .terminal_count_i (terminal_count_i[c]),
                .transfer_mode_o  (transfer_mode_o[2*c+1:2*c]),
                .addr_decrement_o (addr_decrement_o[c]),
                .autoinit_o       (autoinit_o[c]),
                .transfer_type_o  (transfer_type_o[2*c+1:2*c]),
                .reload_o         (reload_o[c]),
                .tc_mask_set_o    (tc_mask_set[c])
            );
        end
    endgenerate

    // ****************************************************************
    // Mask registers and byte pointers
    // ****************************************************************

    reg  [7:0] mask;
    reg  [1:0] byte_ptr;
    reg  [7:0] next_mask;
    reg  [1:0] next_byte_ptr;
    integer    g;

    always @* begin
        next_mask     = mask;
        next_byte_ptr = byte_ptr;
        for (g = 0; g < 2; g = g + 1) begin
            if (do_master_clear[g]) begin
                next_mask[4*g +: 4] = `LDC_MASK_RESET;
            end else if (do_write_mask[g]) begin
                // Upper data bits are reserved and dropped
                next_mask[4*g +: 4] = io_wdata_i[`LDC_MASK_HI:`LDC_MASK_LO];
            end else if (do_clear_mask[g]) begin
                next_mask[4*g +: 4] = 4'h0;
            end
            // Terminal count set wins over a clearing write
            next_mask[4*g +: 4] = next_mask[4*g +: 4] | tc_mask_set[4*g +: 4];

            if (do_master_clear[g] || do_clear_ptr[g]) begin
                next_byte_ptr[g] = 1'b0;
            end else if (do_word_access[g]) begin
                next_byte_ptr[g] = ~byte_ptr[g];
            end
        end
    end

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask           <= {2{`LDC_MASK_RESET}};
            byte_ptr       <= 2'h0;
            master_clear_o <= 2'h0;
            word_access_o  <= 2'h0;
            high_byte_o    <= 2'h0;
        end else begin
            mask           <= next_mask;
            byte_ptr       <= next_byte_ptr;
            // Lets the command, status and request logic clear itself
            master_clear_o <= do_master_clear;
            word_access_o  <= do_word_access;
            // Pointer value before the toggle picks the byte
            high_byte_o    <= byte_ptr;
        end
    end

    assign mask_o = mask;

    // ****************************************************************
    // Request line synchroniser and gating
    // ****************************************************************

    reg  [7:0] req_meta;
    reg  [7:0] req_sync;
    wire [3:0] low_eff;
    wire [3:0] high_raw;
    wire [3:0] high_eff;
    wire       low_group_off;

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_meta <= 8'h00;
            req_sync <= 8'h00;
        end else begin
            req_meta <= channel_request_line_i;
            req_sync <= req_meta;
        end
    end

    // Lower group rides on channel 4, so the upper disable blocks it too
    assign low_group_off = group_disable_i[0] | group_disable_i[1];
    assign low_eff       = req_sync[3:0] & ~mask[3:0] & {4{~low_group_off}};

    // Channel 4 in cascade carries the lower group's demand
    assign high_raw[0]   = (transfer_mode_o[9:8] == `LDC_XFER_CASCADE) ? (|low_eff) : req_sync[4];
    assign high_raw[3:1] = req_sync[7:5];
    assign high_eff      = high_raw & ~mask[7:4] & {4{~group_disable_i[1]}};

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            channel_request_gated_o <= 8'h00;
        end else begin
            channel_request_gated_o <= {high_eff, low_eff};
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************

    reg [7:0] read_word;

    always @* begin
        if (hit_all_mask[0]) begin
            read_word = {4'h0, mask[3:0]};
        end else if (hit_all_mask[1]) begin
            read_word = {4'h0, mask[7:4]};
        end else begin
            read_word = `LDC_UNMAPPED_RDATA;
        end
    end

    // Two entries let a stalled reader lose no answer
    ldc_buf2 #(
        .WIDTH (8)
    ) u_rd_buf (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (rd_take),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (read_word),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i),
        .out_data_o  (rd_data_o)
    );

endmodule

`default_nettype wire

/* tb/ldc_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ldc_defs.vh"
module ldc_props (
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic [7:0]  io_addr_i,
    input wire logic        io_wr_i,
    input wire logic        io_rd_i,
    input wire logic [7:0]  io_wdata_i,
    input wire logic        io_ready_o,
    input wire logic        rd_valid_o,
    input wire logic [7:0]  rd_data_o,
    input wire logic [1:0]  group_disable_i,
    input wire logic [7:0]  terminal_count_i,
    input wire logic [7:0]  channel_request_gated_o,
    input wire logic [7:0]  mask_o,
    input wire logic [15:0] transfer_mode_o,
    input wire logic [7:0]  addr_decrement_o,
    input wire logic [7:0]  autoinit_o,
    input wire logic [15:0] transfer_type_o,
    input wire logic [7:0]  reload_o,
    input wire logic [1:0]  master_clear_o,
    input wire logic [1:0]  word_access_o,
    input wire logic [1:0]  high_byte_o
);
    // ****************************************
    // Lower group port checks, plus count and disable checks on all channels
    // ****************************************
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic       take;
    logic       lo_word;
    logic [7:0] tc_mask;
    logic [7:0] tc_load;
    logic [1:0] sel;
    assign take = io_wr_i && !io_rd_i || io_rd_i && io_ready_o;
    assign lo_word = take && io_addr_i[7:3] == `LDC_LO_WORD_TOP;
    assign tc_mask = terminal_count_i & ~autoinit_o;
    assign tc_load = terminal_count_i & autoinit_o;
    assign sel = io_wdata_i[1:0];
    function automatic logic wa(input logic [7:0] a);
        return io_wr_i && !io_rd_i && io_addr_i == a;
    endfunction
    // Bus tasks leave one idle cycle between accesses
    sequence s_ptr_clr;
        (wa(`LDC_LO_CLEAR_BYTE_PTR) || wa(`LDC_LO_MASTER_CLEAR)) ##1 !take ##1 lo_word;
    endsequence
    sequence s_two_acc;
        lo_word ##1 !take ##1 lo_word;
    endsequence
    chk_mask_write: assert property (wa(`LDC_LO_ALL_MASK) && terminal_count_i[3:0] == 4'h0
        |=> mask_o[3:0] == $past(io_wdata_i[3:0])) else $error("mask write lost");
    chk_clear_mask: assert property (wa(`LDC_LO_CLEAR_MASK) && terminal_count_i[3:0] == 4'h0
        |=> mask_o[3:0] == 4'h0) else $error("clear mask lost");
    chk_master_clear: assert property (wa(`LDC_LO_MASTER_CLEAR)
        |=> mask_o[3:0] == `LDC_MASK_RESET && master_clear_o[0] && autoinit_o[3:0] == 4'h0)
        else $error("master clear incomplete");
    chk_tc_mask: assert property (tc_mask != 8'h00
        |=> (mask_o & $past(tc_mask)) == $past(tc_mask)) else $error("count did not mask");
    chk_tc_reload: assert property (tc_load != 8'h00
        |=> reload_o == $past(tc_load)) else $error("reload pulse wrong");
    chk_mode_fields: assert property (wa(`LDC_LO_CHANNEL_MODE)
        |=> transfer_mode_o[2*$past(sel) +: 2] == $past(io_wdata_i[7:6])
        && addr_decrement_o[$past(sel)] == $past(io_wdata_i[5])
        && autoinit_o[$past(sel)] == $past(io_wdata_i[4])) else $error("mode not stored");
    chk_mode_type: assert property (wa(`LDC_LO_CHANNEL_MODE)
        |=> transfer_type_o[2*$past(sel) +: 2] == ($past(io_wdata_i[7:6]) == `LDC_XFER_CASCADE
        ? `LDC_TYPE_VERIFY : $past(io_wdata_i[3:2]))) else $error("type not stored");
    chk_ptr_clear: assert property (s_ptr_clr |=> word_access_o[0] && !high_byte_o[0])
        else $error("pointer not cleared");
    chk_ptr_toggle: assert property (s_two_acc
        |=> word_access_o[0] && high_byte_o[0] != $past(high_byte_o[0], 2)) else $error("no toggle");
    chk_read_mask: assert property (io_rd_i && io_ready_o && !rd_valid_o && io_addr_i == `LDC_LO_ALL_MASK
        |=> rd_valid_o && rd_data_o == {4'h0, $past(mask_o[3:0])}) else $error("mask read wrong");
    chk_group_off: assert property (group_disable_i[1] [*4]
        |-> channel_request_gated_o == 8'h00) else $error("disabled group requests");
endmodule
`default_nettype wire

/* tb/ldc_periph_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ldc_periph_model (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [7:0] want_i,
    input  wire logic       slow_i,
    output var  logic [7:0] req_o
);
    // ****************************************
    // Request pins, prompt or four cycles late
    // ****************************************
    logic [2:0] wait_cnt;
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_o <= 8'h00;
            wait_cnt <= 3'h0;
        end else if (want_i == req_o) begin
            wait_cnt <= slow_i ? 3'h4 : 3'h0;
        end else if (wait_cnt != 3'h0) begin
            wait_cnt <= wait_cnt - 3'h1;
        end else begin
            req_o <= want_i;
        end
    end
endmodule
`default_nettype wire

/* tb/legacy_dma_channel_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ldc_defs.vh"
module legacy_dma_channel_control_tb;
    logic        ref_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [7:0]  io_addr_i = 8'h00;
    logic        io_wr_i = 1'b0;
    logic        io_rd_i = 1'b0;
    logic [7:0]  io_wdata_i = 8'h00;
    logic        rd_ready_i = 1'b0;
    logic [1:0]  group_disable_i = 2'h0;
    logic [7:0]  terminal_count_i = 8'h00;
    logic [7:0]  want = 8'h00;
    logic        slow = 1'b0;
    wire         io_ready_o, rd_valid_o;
    wire  [7:0]  rd_data_o, channel_request_line_i, channel_request_gated_o, mask_o;
    wire  [7:0]  addr_decrement_o, autoinit_o, reload_o;
    wire  [15:0] transfer_mode_o, transfer_type_o;
    wire  [1:0]  master_clear_o, word_access_o, high_byte_o;
    int          miscompares = 0;
    int          compares = 0;
    logic [31:0] seed = 32'h4FBF;
    logic [7:0]  mode_sh [0:7];
    always #10 ref_clk_i = ~ref_clk_i;
    ldc_top dut_u (.*);
    ldc_periph_model peer_u (.ref_clk_i, .reset_n_i, .want_i(want), .slow_i(slow), .req_o(channel_request_line_i));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] port(input int g, input int k);
        return g ? 8'hD6 + 8'(2 * k) : 8'h0B + 8'(k);
    endfunction
    // Lower mask is held at 05 during the request runs
    function automatic logic [7:0] exp_gate(input logic [7:0] r, input logic [1:0] d);
        logic [7:0] e;
        e = r & ~8'h05;
        if (d != 2'h0) e[3:0] = 4'h0;
        // Channel 4 in cascade: its own pin is ignored
        e[4] = |e[3:0];
        if (d[1]) e[7:4] = 4'h0;
        return e;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        io_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        io_addr_i <= a;
        io_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        io_rd_i <= 1'b0;
        #1;
    endtask
    task automatic pop(input logic [7:0] e);
        int n;
        n = 0;
        while (rd_valid_o !== 1'b1 && n < 20) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        check({rd_valid_o, rd_data_o}, {1'b1, e});
        @(posedge ref_clk_i);
        rd_ready_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_ready_i <= 1'b0;
        #1;
    endtask
    task automatic chk_modes();
        for (int c = 0; c < 8; c++) begin
            check(transfer_mode_o[2*c +: 2], mode_sh[c][7:6]);
            check(addr_decrement_o[c], mode_sh[c][5]);
            check(autoinit_o[c], mode_sh[c][4]);
            check(transfer_type_o[2*c +: 2], mode_sh[c][7:6] == 2'h3 ? 2'h0 : mode_sh[c][3:2]);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        miscompares++;
        close_out();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] r;
        logic [7:0]  v;
        logic [7:0]  m;
        for (int c = 0; c < 8; c++) mode_sh[c] = 8'h00;
        repeat (10) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        #1;
        check(mask_o, 8'hFF);
        chk_modes();
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            v = i < 2 ? 8'(15 * i) : {4'h0, r[3:0]};
            wr(port(i % 2, 4), v);
            check(mask_o[4*(i%2) +: 4], v[3:0]);
            rd(port(i % 2, 4));
            pop(v);
        end
        rd(8'h3F);
        pop(`LDC_UNMAPPED_RDATA);
        // Fill the read buffer, one refused read, then drain
        wr(8'h0F, 8'h05);
        rd(8'h0F);
        rd(8'h0F);
        check(io_ready_o, 1'b0);
        rd(8'h3F);
        pop(8'h05);
        pop(8'h05);
        check(rd_valid_o, 1'b0);
        for (int g = 0; g < 2; g++) begin
            r = rnd();
            wr(port(g, 3), r[7:0]);
            check(mask_o[4*g +: 4], 4'h0);
        end
        for (int i = 0; i < 32; i++) begin
            r = rnd();
            v = {i[3:2], r[1:0], i[1:0], r[3:2]};
            wr(port(i / 16, 0), v);
            mode_sh[4*(i/16) + v[1:0]] = v;
            chk_modes();
        end
        wr(8'h0B, 8'h10);
        mode_sh[0] = 8'h10;
        wr(8'hD6, 8'h01);
        mode_sh[5] = 8'h01;
        m = 8'h00;
        for (int c = 0; c < 8; c++) begin
            @(posedge ref_clk_i);
            terminal_count_i <= 8'h01 << c;
            @(posedge ref_clk_i);
            terminal_count_i <= 8'h00;
            #1;
            if (!mode_sh[c][4]) m[c] = 1'b1;
            check(reload_o, mode_sh[c][4] ? 8'h01 << c : 8'h00);
            check(mask_o, m);
        end
        for (int g = 0; g < 2; g++) begin
            wr(port(g, 1), 8'(rnd()));
            for (int k = 0; k < 3; k++) begin
                wr(g ? 8'hC2 : 8'h02, 8'h5A);
                check({word_access_o[g], high_byte_o[g]}, {1'b1, k[0]});
            end
            wr(port(g, 1), 8'h00);
            wr(g ? 8'hC2 : 8'h02, 8'h5A);
            check(high_byte_o[g], 1'b0);
            wr(port(g, 2), 8'hA5);
            check(master_clear_o[g], 1'b1);
            check(mask_o[4*g +: 4], 4'hF);
            for (int c = 0; c < 4; c++) mode_sh[4*g + c] = 8'h00;
            chk_modes();
            wr(g ? 8'hC2 : 8'h02, 8'h5A);
            check(high_byte_o[g], 1'b0);
            wr(port(g, 3), 8'hFF);
        end
        wr(8'h0F, 8'h05);
        wr(8'hD6, 8'hC0);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            want <= r[7:0];
            slow <= i[0];
            group_disable_i <= i[2:1];
            repeat (12) @(posedge ref_clk_i);
            #1;
            check(channel_request_gated_o, exp_gate(r[7:0], i[2:1]));
        end
        // Mid-run reset must bring back the idle state
        reset_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        #1;
        check({mask_o, rd_valid_o, word_access_o}, {8'hFF, 1'b0, 2'h0});
        check(transfer_mode_o, 16'h0000);
        close_out();
    end
endmodule
bind ldc_top ldc_props chk_u (.*);
`default_nettype wire
